/* rtl/meqc_chain.sv */
// mono equalizer, three-band compander and fine volume chain
//
// Functional notes
// - five biquad sections with their own coefficients form the equalizer.
// - the equalizer output is the cascade of all five sections.
// - a three-band compander follows that can compress and expand.
// - the gain curve has three regions of threshold, offset, ratio type and ratio.
// - one curve serves all bands while each band keeps its own time constants.
// - each band averages its energy over a programmable window and compares it to the curve.
// - each band smooths its gain with an attack time and a separate release time.
// - each band gets its frequency range from its own biquad section.
// - the bands are summed each through its own mixer gain.
// - the mixer gains are signed so a negative one inverts the band.
// - the fine volume gain is held between -0.25 dB and +0.25 dB.
// - the mono input is left, right or the average of both.
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module meqc_chain (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic [31:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [31:0] o_reg_rdata,
  // sample stream in
  input wire logic i_in_valid,
  input wire meqc_pkg::meqc_pair_s i_in,
  // sample stream out
  output logic o_out_valid,
  output logic signed [23:0] o_out
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  meqc_pkg::meqc_state_e state_r;
  logic [2:0] idx_r;
  logic signed [23:0] work_r;
  logic signed [50:0] acc_r;
  logic [2:0] ctrl_r;
  logic [15:0] vol_r;
  logic signed [23:0] coef_r [64];
  logic [31:0] rgn_r [3];
  logic [15:0] ealpha_r [3];
  logic [15:0] aalpha_r [3];
  logic [15:0] ralpha_r [3];
  logic signed [23:0] mixg_r [3];
  logic signed [23:0] x1_r [8];
  logic signed [23:0] x2_r [8];
  logic signed [23:0] y1_r [8];
  logic signed [23:0] y2_r [8];
  logic signed [23:0] band_r [3];
  logic [23:0] en_r [3];
  logic signed [15:0] g_r [3];

  // ----------------------------------------------------------------
  // arithmetic helpers
  // ----------------------------------------------------------------
  // clip a wide sum to a 24-bit sample
  function automatic logic signed [23:0] sat24(input logic signed [50:0] v);
    if (v > meqc_pkg::ACC_MAX) begin
      return 24'sh7FFFFF;
    end else if (v < meqc_pkg::ACC_MIN) begin
      return -24'sh800000;
    end
    return v[23:0];
  endfunction

  // one direct-form biquad, feedback terms stored pre-negated
  function automatic logic signed [23:0] bq(input logic [2:0] k,
                                            input logic signed [23:0] x);
    logic [5:0] b;
    logic signed [50:0] acc;
    b = {k, 3'h0};
    acc = 51'(coef_r[b] * x) + 51'(coef_r[b + 6'h1] * x1_r[k])
        + 51'(coef_r[b + 6'h2] * x2_r[k]) + 51'(coef_r[b + 6'h3] * y1_r[k])
        + 51'(coef_r[b + 6'h4] * y2_r[k]);
    return sat24(acc >>> meqc_pkg::COEF_FRAC);
  endfunction

  // level in whole dB below full scale, about 6 dB per bit
  function automatic logic signed [9:0] lvl_db(input logic [23:0] e);
    logic signed [9:0] r;
    r = meqc_pkg::LVL_FLOOR;
    for (int i = 0; i < 24; i++) begin
      if (e[i]) begin
        r = 10'(6 * i) - meqc_pkg::LVL_BASE;
      end
    end
    return r;
  endfunction

  // shared three-region curve, returns target gain in Q8.8 dB
  function automatic logic signed [15:0] curve(input logic signed [9:0] lvl);
    logic [1:0] s;
    logic signed [10:0] d;
    logic signed [20:0] m;
    logic signed [9:0] t;
    s = 2'h0;
    for (int i = 0; i < 3; i++) begin
      if (lvl >= $signed(rgn_r[i][meqc_pkg::RGN_THR_LSB +: 8])) begin
        s = 2'(i);
      end
    end
    d = 11'(lvl) - 11'($signed(rgn_r[s][meqc_pkg::RGN_THR_LSB +: 8]));
    m = (d * $signed({1'b0, rgn_r[s][meqc_pkg::RGN_SLOPE_LSB +: 8]})) >>> 4;
    if (!rgn_r[s][meqc_pkg::RGN_TYPE_BIT]) begin
      m = -m;
    end
    m = m + 21'($signed(rgn_r[s][meqc_pkg::RGN_OFF_LSB +: 8]));
    if (m > 21'(meqc_pkg::GAIN_DB_MAX)) begin
      t = meqc_pkg::GAIN_DB_MAX;
    end else if (m < 21'(meqc_pkg::GAIN_DB_MIN)) begin
      t = meqc_pkg::GAIN_DB_MIN;
    end else begin
      t = m[9:0];
    end
    return {t[7:0], 8'h00};
  endfunction

  // Q8.8 dB to a linear Q.14 factor, steps of 1 dB
  function automatic logic [19:0] db2lin(input logic signed [15:0] g);
    logic [8:0] m;
    logic [4:0] q;
    logic [2:0] r;
    logic [19:0] base;
    m = 9'($signed(g[15:8])) + meqc_pkg::DB_BIAS; // cuts stay negative before the bias
    q = 5'(m / 9'h006);
    r = 3'(m % 9'h006);
    base = {5'h00, meqc_pkg::DB_STEP[r]};
    if (q >= meqc_pkg::DB_SHIFT_ZERO) begin
      return base << (q - meqc_pkg::DB_SHIFT_ZERO);
    end
    return base >> (meqc_pkg::DB_SHIFT_ZERO - q);
  endfunction

  // ----------------------------------------------------------------
  // input select and phase
  // ----------------------------------------------------------------
  // mono source pick and optional inversion
  logic signed [23:0] in_avg;
  logic signed [23:0] in_sel;
  logic signed [23:0] in_mono;
  assign in_avg = 24'((25'(i_in.left) + 25'(i_in.right)) >>> 1);
  assign in_sel = (ctrl_r[1:0] == meqc_pkg::MIX_LEFT) ? i_in.left :
                  (ctrl_r[1:0] == meqc_pkg::MIX_RIGHT) ? i_in.right : in_avg;
  assign in_mono = ctrl_r[meqc_pkg::CTRL_PHASE_BIT] ? sat24(-51'(in_sel)) : in_sel;

  // ----------------------------------------------------------------
  // datapath terms
  // ----------------------------------------------------------------
  // biquad in use: eq section or band splitter
  logic [2:0] bq_k;
  logic signed [23:0] bq_y;
  logic [1:0] bi;
  assign bq_k = (state_r == meqc_pkg::ST_EQ) ? idx_r : 3'(idx_r + meqc_pkg::BAND_BQ_BASE);
  always_comb bq_y = bq(bq_k, work_r);
  assign bi = idx_r[1:0];

  // energy average per band
  logic [23:0] mag;
  logic signed [24:0] e_diff;
  logic signed [41:0] e_step;
  logic [23:0] en_nxt;
  assign mag = band_r[bi][23] ? 24'(-band_r[bi]) : band_r[bi];
  assign e_diff = $signed({1'b0, mag}) - $signed({1'b0, en_r[bi]});
  assign e_step = e_diff * $signed({1'b0, ealpha_r[bi]});
  assign en_nxt = 24'($signed({1'b0, en_r[bi]}) + (e_step >>> meqc_pkg::ALPHA_SHIFT));

  // curve lookup and attack or release smoothing
  logic signed [15:0] tgt;
  logic signed [16:0] g_diff;
  logic [15:0] g_alpha;
  logic signed [33:0] g_step;
  logic signed [15:0] g_nxt;
  always_comb tgt = curve(lvl_db(en_nxt));
  assign g_diff = 17'(tgt) - 17'(g_r[bi]);
  assign g_alpha = (tgt < g_r[bi]) ? aalpha_r[bi] : ralpha_r[bi];
  assign g_step = g_diff * $signed({1'b0, g_alpha});
  assign g_nxt = 16'(g_r[bi] + (g_step >>> meqc_pkg::ALPHA_SHIFT));

  // band gain, signed mixer gain and sum
  logic signed [23:0] bg;
  logic signed [50:0] acc_nxt;
  assign bg = sat24(51'(band_r[bi] * $signed({1'b0, db2lin(g_r[bi])})) >>> meqc_pkg::GAIN_FRAC);
  assign acc_nxt = acc_r + 51'(bg * mixg_r[bi]);

  // fine volume, factor held inside its range
  logic signed [23:0] mix_out;
  logic [15:0] vol_c;
  logic signed [23:0] vol_y;
  assign mix_out = sat24(acc_r >>> meqc_pkg::COEF_FRAC);
  assign vol_c = (vol_r < meqc_pkg::VOL_MIN) ? meqc_pkg::VOL_MIN :
                 (vol_r > meqc_pkg::VOL_MAX) ? meqc_pkg::VOL_MAX : vol_r;
  assign vol_y = sat24(51'(mix_out * $signed({1'b0, vol_c})) >>> meqc_pkg::GAIN_FRAC);

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  // address classes and read selection
  logic is_coef;
  logic is_rgn;
  logic is_band;
  logic is_gain;
  logic [5:0] cidx;
  logic [1:0] ridx;
  logic [7:0] boff;
  logic [1:0] bsel;
  logic [31:0] band_rd;
  logic [31:0] rd_mux;
  assign is_coef = (i_reg_addr >= meqc_pkg::ADDR_COEF0) && (i_reg_addr <= meqc_pkg::ADDR_COEF_END);
  assign is_rgn = (i_reg_addr >= meqc_pkg::ADDR_RGN0) && (i_reg_addr <= meqc_pkg::ADDR_RGN_END);
  assign is_band = (i_reg_addr >= meqc_pkg::ADDR_BAND0) && (i_reg_addr <= meqc_pkg::ADDR_BAND_END);
  assign is_gain = (i_reg_addr >= meqc_pkg::ADDR_GAIN0) && (i_reg_addr <= meqc_pkg::ADDR_GAIN_END);
  assign cidx = 6'(i_reg_addr - meqc_pkg::ADDR_COEF0);
  assign ridx = 2'(i_reg_addr - (is_gain ? meqc_pkg::ADDR_GAIN0 : meqc_pkg::ADDR_RGN0));
  assign boff = i_reg_addr - meqc_pkg::ADDR_BAND0;
  assign bsel = boff[3:2];
  assign band_rd = (boff[1:0] == meqc_pkg::BAND_F_ENERGY) ? {16'h0000, ealpha_r[bsel]} :
                   (boff[1:0] == meqc_pkg::BAND_F_ATTACK) ? {16'h0000, aalpha_r[bsel]} :
                   (boff[1:0] == meqc_pkg::BAND_F_RELEASE) ? {16'h0000, ralpha_r[bsel]} :
                   {8'h00, mixg_r[bsel]};
  assign rd_mux = (i_reg_addr == meqc_pkg::ADDR_CTRL) ? {29'h0, ctrl_r} :
                  (i_reg_addr == meqc_pkg::ADDR_STATUS) ? {28'h0, state_r != meqc_pkg::ST_IDLE,
                                                           state_r} :
                  (i_reg_addr == meqc_pkg::ADDR_VOL) ? {16'h0000, vol_r} :
                  is_gain ? {16'h0000, g_r[ridx]} :
                  is_coef ? {8'h00, coef_r[cidx]} :
                  is_rgn ? rgn_r[ridx] :
                  is_band ? band_rd : 32'h0000_0000;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // writes take effect at once, software stages them between samples
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ctrl_r <= meqc_pkg::CTRL_RST;
      vol_r <= meqc_pkg::VOL_RST;
      for (int i = 0; i < 64; i++) begin
        coef_r[i] <= (i[2:0] == 3'h0) ? meqc_pkg::COEF_UNITY : 24'sh000000;
      end
      rgn_r[0] <= meqc_pkg::RGN0_RST;
      rgn_r[1] <= meqc_pkg::RGN1_RST;
      rgn_r[2] <= meqc_pkg::RGN2_RST;
      for (int i = 0; i < 3; i++) begin
        ealpha_r[i] <= meqc_pkg::ALPHA_E_RST;
        aalpha_r[i] <= meqc_pkg::ALPHA_A_RST;
        ralpha_r[i] <= meqc_pkg::ALPHA_R_RST;
        mixg_r[i] <= (i == 0) ? meqc_pkg::COEF_UNITY : 24'sh000000;
      end
    end else if (i_reg_wr) begin
      if (i_reg_addr == meqc_pkg::ADDR_CTRL) begin
        ctrl_r <= i_reg_wdata[2:0];
      end
      if (i_reg_addr == meqc_pkg::ADDR_VOL) begin
        vol_r <= i_reg_wdata[15:0];
      end
      if (is_coef) begin
        coef_r[cidx] <= i_reg_wdata[23:0];
      end
      if (is_rgn) begin
        rgn_r[ridx] <= i_reg_wdata;
      end
      if (is_band) begin
        case (boff[1:0])
          meqc_pkg::BAND_F_ENERGY: ealpha_r[bsel] <= i_reg_wdata[15:0];
          meqc_pkg::BAND_F_ATTACK: aalpha_r[bsel] <= i_reg_wdata[15:0];
          meqc_pkg::BAND_F_RELEASE: ralpha_r[bsel] <= i_reg_wdata[15:0];
          default: mixg_r[bsel] <= i_reg_wdata[23:0];
        endcase
      end
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 32'h0000_0000;
    end else begin
      o_reg_rdata <= i_reg_rd ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // sample sequencer
  // ----------------------------------------------------------------
  // one stage per cycle; a sample offered while busy is dropped
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= meqc_pkg::ST_IDLE;
      idx_r <= 3'h0;
      work_r <= 24'sh000000;
      acc_r <= 51'sh0;
      o_out_valid <= 1'b0;
      o_out <= 24'sh000000;
      for (int i = 0; i < 8; i++) begin
        x1_r[i] <= 24'sh000000;
        x2_r[i] <= 24'sh000000;
        y1_r[i] <= 24'sh000000;
        y2_r[i] <= 24'sh000000;
      end
      for (int i = 0; i < 3; i++) begin
        band_r[i] <= 24'sh000000;
        en_r[i] <= 24'h000000;
        g_r[i] <= 16'sh0000;
      end
    end else begin
      o_out_valid <= 1'b0;
      case (state_r)
        meqc_pkg::ST_IDLE: begin
          idx_r <= 3'h0;
          acc_r <= 51'sh0;
          if (i_in_valid) begin
            work_r <= in_mono;
            state_r <= meqc_pkg::ST_EQ;
          end
        end
        meqc_pkg::ST_EQ, meqc_pkg::ST_BAND: begin
          x2_r[bq_k] <= x1_r[bq_k];
          x1_r[bq_k] <= work_r;
          y2_r[bq_k] <= y1_r[bq_k];
          y1_r[bq_k] <= bq_y;
          idx_r <= 3'(idx_r + 3'h1);
          if (state_r == meqc_pkg::ST_EQ) begin
            work_r <= bq_y;
            if (idx_r == meqc_pkg::NUM_EQ_LAST) begin
              idx_r <= 3'h0;
              state_r <= meqc_pkg::ST_BAND;
            end
          end else begin
            band_r[bi] <= bq_y;
            if (bi == meqc_pkg::NUM_BAND_LAST) begin
              idx_r <= 3'h0;
              state_r <= meqc_pkg::ST_DYN;
            end
          end
        end
        meqc_pkg::ST_DYN: begin
          en_r[bi] <= en_nxt;
          g_r[bi] <= g_nxt;
          idx_r <= 3'(idx_r + 3'h1);
          if (bi == meqc_pkg::NUM_BAND_LAST) begin
            idx_r <= 3'h0;
            state_r <= meqc_pkg::ST_MIX;
          end
        end
        meqc_pkg::ST_MIX: begin
          acc_r <= acc_nxt;
          idx_r <= 3'(idx_r + 3'h1);
          if (bi == meqc_pkg::NUM_BAND_LAST) begin
            state_r <= meqc_pkg::ST_VOL;
          end
        end
        meqc_pkg::ST_VOL: begin
          o_out <= vol_y;
          o_out_valid <= 1'b1;
          state_r <= meqc_pkg::ST_IDLE;
        end
        default: begin
          state_r <= meqc_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* rtl/meqc_pkg.sv */
// constants, register map and carrier types of the mono eq and compander chain
package meqc_pkg;

  // ----------------------------------------------------------------
  // datapath formats
  // ----------------------------------------------------------------
  localparam int COEF_FRAC = 22;
  localparam int GAIN_FRAC = 14;
  localparam int ALPHA_SHIFT = 16;
  localparam logic [2:0] NUM_EQ_LAST = 3'h4;
  localparam logic [2:0] BAND_BQ_BASE = 3'h5;
  localparam logic [1:0] NUM_BAND_LAST = 2'h2;
  localparam logic signed [50:0] ACC_MAX = 51'sh7FFFFF;
  localparam logic signed [50:0] ACC_MIN = -51'sh800000;

  // ----------------------------------------------------------------
  // register map, word addresses on the plain port
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h01;
  localparam logic [7:0] ADDR_VOL = 8'h02;
  localparam logic [7:0] ADDR_GAIN0 = 8'h04;
  localparam logic [7:0] ADDR_GAIN_END = 8'h06;
  localparam logic [7:0] ADDR_COEF0 = 8'h10;
  localparam logic [7:0] ADDR_COEF_END = 8'h4F;
  localparam logic [7:0] ADDR_RGN0 = 8'h50;
  localparam logic [7:0] ADDR_RGN_END = 8'h52;
  localparam logic [7:0] ADDR_BAND0 = 8'h58;
  localparam logic [7:0] ADDR_BAND_END = 8'h63;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_MIX_LSB = 0;
  localparam int CTRL_PHASE_BIT = 2;
  localparam int RGN_THR_LSB = 0;
  localparam int RGN_OFF_LSB = 8;
  localparam int RGN_TYPE_BIT = 16;
  localparam int RGN_SLOPE_LSB = 24;
  localparam logic [1:0] BAND_F_ENERGY = 2'h0;
  localparam logic [1:0] BAND_F_ATTACK = 2'h1;
  localparam logic [1:0] BAND_F_RELEASE = 2'h2;
  localparam logic [1:0] BAND_F_MIXG = 2'h3;

  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [2:0] CTRL_RST = 3'h2;
  localparam logic [15:0] VOL_RST = 16'h4000;
  localparam logic [15:0] VOL_MIN = 16'h3E2F;
  localparam logic [15:0] VOL_MAX = 16'h41DE;
  localparam logic signed [23:0] COEF_UNITY = 24'sh400000;
  localparam logic [31:0] RGN0_RST = 32'h0001_0084;
  localparam logic [31:0] RGN1_RST = 32'h0700_00E0;
  localparam logic [31:0] RGN2_RST = 32'h1000_F9F1;
  localparam logic [15:0] ALPHA_E_RST = 16'h0040;
  localparam logic [15:0] ALPHA_A_RST = 16'h0080;
  localparam logic [15:0] ALPHA_R_RST = 16'h0020;
  localparam logic signed [9:0] GAIN_DB_MAX = 10'sh018;
  localparam logic signed [9:0] GAIN_DB_MIN = -10'sh078;
  localparam logic signed [9:0] LVL_FLOOR = -10'sh090;
  localparam logic signed [9:0] LVL_BASE = 10'sh08A;
  localparam logic [8:0] DB_BIAS = 9'h090;
  localparam logic [4:0] DB_SHIFT_ZERO = 5'h18;
  localparam logic [14:0] DB_STEP [6] = '{15'h4000, 15'h47D7, 15'h50A3,
                                          15'h5A82, 15'h6598, 15'h7209};

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [23:0] left;
    logic signed [23:0] right;
  } meqc_pair_s;

  typedef enum logic [1:0] {
    MIX_LEFT = 2'h0,
    MIX_RIGHT = 2'h1,
    MIX_AVG = 2'h2
  } meqc_mix_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_EQ = 3'h1,
    ST_BAND = 3'h2,
    ST_DYN = 3'h3,
    ST_MIX = 3'h4,
    ST_VOL = 3'h5
  } meqc_state_e;

endpackage

/* verif/meqc_chain_chk.sv */
// port assertions of the mono eq and compander chain
`timescale 1ns/1ns
`default_nettype none

module meqc_chain_chk (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic [31:0] o_reg_rdata,
  // sample stream
  input wire logic i_in_valid,
  input wire logic o_out_valid,
  input wire logic signed [23:0] o_out
);
  logic [4:0] pend_r;
  logic take;

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // samples in flight
  // ----------------------------------------------------------------
  // a sample is taken when the sequencer is idle, already in the output cycle
  assign take = i_in_valid && (pend_r <= 5'h01);

  // counts down the 16 edges from take to visible output
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_r <= 5'h00;
    end else if (take) begin
      pend_r <= 5'h10;
    end else if (pend_r != 5'h00) begin
      pend_r <= pend_r - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_out_latency: assert property (take |-> ##16 o_out_valid)
    else $error("output sample late or missing");
  a_out_single: assert property (o_out_valid |=> !o_out_valid)
    else $error("output strobe longer than one cycle");
  a_no_spurious: assert property (o_out_valid |-> pend_r == 5'h01)
    else $error("output sample without a taken input");
  a_out_holds: assert property (!o_out_valid |-> $stable(o_out))
    else $error("output sample changed between strobes");
  a_rd_idle: assert property (!i_reg_rd |=> o_reg_rdata == 32'h0)
    else $error("read data not zero after idle cycle");
  a_ctrl_narrow: assert property (i_reg_rd && i_reg_addr == meqc_pkg::ADDR_CTRL
    |=> o_reg_rdata[31:3] == 29'h0) else $error("mix control upper bits set");
  a_status_narrow: assert property (i_reg_rd && i_reg_addr == meqc_pkg::ADDR_STATUS
    |=> o_reg_rdata[31:4] == 28'h0) else $error("status upper bits set");
  a_vol_narrow: assert property (i_reg_rd && i_reg_addr == meqc_pkg::ADDR_VOL
    |=> o_reg_rdata[31:16] == 16'h0) else $error("volume upper bits set");

  // main scenarios
  c_take: cover property (take);
  c_neg_out: cover property (o_out_valid && o_out[23]);
  c_dropped: cover property (i_in_valid && pend_r != 5'h00);
endmodule

bind meqc_chain meqc_chain_chk meqc_chain_chk_i (
  .i_core_clk(i_core_clk),
  .i_rst(i_rst),
  .i_reg_addr(i_reg_addr),
  .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata),
  .i_in_valid(i_in_valid),
  .o_out_valid(o_out_valid),
  .o_out(o_out)
);

`default_nettype wire

/* verif/meqc_src_model.sv */
// behavioural model of the upstream mix stage feeding stereo pairs
`timescale 1ns/1ns
`default_nettype none

module meqc_src_model (
  // clock
  input wire logic i_core_clk,
  // command from the bench
  input wire logic i_send,
  input wire meqc_pkg::meqc_pair_s i_pair,
  // stereo stream out
  output logic o_valid,
  output meqc_pkg::meqc_pair_s o_pair
);
  initial begin
    o_valid = 1'b0;
    o_pair = '0;
  end

  // one-cycle strobe; data inverted between frames so no stale value lingers
  always @(posedge i_core_clk) begin
    o_valid <= i_send;
    o_pair <= i_send ? i_pair : ~o_pair;
  end
endmodule

`default_nettype wire

/* verif/test_meqc_chain.sv */
// self-checking bench of the mono eq and compander chain
`timescale 1ns/1ns
`default_nettype none

module test_meqc_chain;
  typedef struct {
    logic signed [23:0] val;
    int kind;
  } meqc_note_s;

  logic i_core_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic send = 1'b0;
  logic rd_d = 1'b0;
  logic [31:0] rdata;
  logic in_valid;
  logic out_valid;
  logic signed [23:0] out;
  meqc_pkg::meqc_pair_s pair = '0;
  meqc_pkg::meqc_pair_s in_pair;
  meqc_note_s nt;
  meqc_note_s smp_q[$];
  logic [31:0] rd_q[$];
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed = 32'hb10c580b;
  int i;
  logic signed [23:0] l;
  logic signed [23:0] r;
  logic signed [24:0] s;
  logic signed [23:0] gl [5] = '{24'h400000, 24'hC00000, 24'h0, 24'h0, 24'h400000};
  logic signed [23:0] gm [5] = '{24'h0, 24'h0, 24'h400000, 24'h0, 24'h400000};
  logic signed [23:0] gh [5] = '{24'h0, 24'h0, 24'h0, 24'h200000, 24'hC00000};
  int half [5] = '{2, -2, 2, 1, 2};

  meqc_src_model meqc_src_model_i (.i_core_clk(i_core_clk), .i_send(send), .i_pair(pair),
    .o_valid(in_valid), .o_pair(in_pair));
  meqc_chain meqc_chain_i (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata),
    .i_in_valid(in_valid), .i_in(in_pair), .o_out_valid(out_valid), .o_out(out));

  always #2 i_core_clk = ~i_core_clk;

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // settings go in between sample frames only
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_core_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge i_core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_core_clk);
    rd <= 1'b0;
  endtask

  // one stereo pair, then a gap well over the busy time
  task automatic smp(input logic signed [23:0] a, input logic signed [23:0] b,
                     input logic signed [23:0] e, input int k);
    smp_q.push_back('{e, k});
    @(posedge i_core_clk);
    send <= 1'b1;
    pair <= '{a, b};
    @(posedge i_core_clk);
    send <= 1'b0;
    repeat (22) @(posedge i_core_clk);
  endtask

  function automatic logic signed [23:0] rnd();
    logic [31:0] v;
    v = $random(seed);
    rnd = {{4{v[19]}}, v[19:1], 1'b0};
  endfunction

  function automatic logic [23:0] mag(input logic signed [23:0] v);
    mag = v[23] ? -v : v;
  endfunction

  // ----------------------------------------------------------------
  // monitor: compares each result with the oldest note
  // ----------------------------------------------------------------
  always @(posedge i_core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      end_sim();
    end
    if (rd_d) chk("read data", rd_q.pop_front(), rdata);
    rd_d <= rd;
    if (!i_rst && out_valid !== 1'b0) begin
      if (smp_q.size() == 0) chk("unexpected output", 32'h0, 32'h1);
      else begin
        nt = smp_q.pop_front();
        if (nt.kind == 0) chk("out", {{8{nt.val[23]}}, nt.val}, {{8{out[23]}}, out});
        if (nt.kind == 1) chk("cut", 32'h1, {31'h0, mag(out) < mag(nt.val)});
        if (nt.kind == 1) chk("cut floor", 32'h1, {31'h0, mag(out) >= mag(nt.val) >> 1});
        if (nt.kind == 2) chk("boost", 32'h1, {31'h0, mag(out) > mag(nt.val)});
        if (nt.kind == 2) chk("boost ceiling", 32'h1, {31'h0, mag(out) <= mag(nt.val) << 1});
      end
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    rd_reg(meqc_pkg::ADDR_CTRL, 32'h2);
    rd_reg(meqc_pkg::ADDR_VOL, 32'h4000);
    rd_reg(meqc_pkg::ADDR_RGN0, meqc_pkg::RGN0_RST);
    rd_reg(8'h59, 32'h0080);
    rd_reg(8'h5A, 32'h0020);
    rd_reg(8'h38, 32'h400000);
    rd_reg(meqc_pkg::ADDR_GAIN0, 32'h0);
    rd_reg(meqc_pkg::ADDR_STATUS, 32'h0);
    wr_reg(8'h03, 32'hFFFF);
    rd_reg(8'h03, 32'h0);
    // flat curve: every region 0 dB
    for (i = 0; i < 3; i++) wr_reg(meqc_pkg::ADDR_RGN0 + 8'(i), 32'h80);
    // every mix mode, then phase invert
    for (i = 0; i < 5; i++) begin
      wr_reg(meqc_pkg::ADDR_CTRL, 32'(i));
      l = rnd();
      r = rnd();
      s = l + r;
      smp(l, r, i == 0 ? l : i == 1 ? r : i == 4 ? -l : s[24:1], 0);
    end
    wr_reg(meqc_pkg::ADDR_CTRL, 32'h0);
    // band mixer gains, signed
    for (i = 0; i < 5; i++) begin
      wr_reg(8'h5B, {8'h0, gl[i]});
      wr_reg(8'h5F, {8'h0, gm[i]});
      wr_reg(8'h63, {8'h0, gh[i]});
      l = rnd();
      smp(l, 24'h0, 24'((32'(l) * half[i]) >>> 1), 0);
    end
    wr_reg(8'h5F, 32'h0);
    wr_reg(8'h63, 32'h0);
    // eq sections one and five at one half each
    wr_reg(8'h10, 32'h200000);
    smp(24'h10000, 24'h0, 24'h8000, 0);
    wr_reg(8'h30, 32'h200000);
    smp(24'h10000, 24'h0, 24'h4000, 0);
    wr_reg(8'h10, 32'h400000);
    wr_reg(8'h30, 32'h400000);
    // fine volume clamped to its limits, read back raw
    wr_reg(meqc_pkg::ADDR_VOL, 32'h8000);
    rd_reg(meqc_pkg::ADDR_VOL, 32'h8000);
    smp(24'h10000, 24'h0, 24'h10778, 0);
    wr_reg(meqc_pkg::ADDR_VOL, 32'h0);
    smp(24'h10000, 24'h0, 24'hF8BC, 0);
    wr_reg(meqc_pkg::ADDR_VOL, 32'h4000);
    // a second pair while busy is dropped
    smp_q.push_back('{24'h1234, 0});
    @(posedge i_core_clk);
    send <= 1'b1;
    pair <= '{24'h1234, 24'h0};
    @(posedge i_core_clk);
    send <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    smp(24'h5678, 24'h0, 24'h0, 3);
    void'(smp_q.pop_back());
    // fast band time constants, then cut and boost
    for (i = 0; i < 3; i++) wr_reg(8'h58 + 8'(i), 32'h8000);
    for (i = 0; i < 3; i++) wr_reg(meqc_pkg::ADDR_RGN0 + 8'(i), 32'hFA80);
    for (i = 0; i < 12; i++) smp(24'h10000, 24'h0, 24'h10000, i < 8 ? 3 : 1);
    for (i = 0; i < 3; i++) wr_reg(meqc_pkg::ADDR_RGN0 + 8'(i), 32'h10680);
    for (i = 0; i < 12; i++) smp(24'h10000, 24'h0, 24'h10000, i < 8 ? 3 : 2);
    repeat (40) @(posedge i_core_clk);
    chk("notes left", 32'h0, 32'(smp_q.size()));
    end_sim();
  end
endmodule

`default_nettype wire
